// ===== src/gpe_consts.vh
`ifndef GPE_CONSTS_VH
`define GPE_CONSTS_VH

// ==========================================================
// register offsets
`define GPE_OFS_INVERT_B 8'h0C
`define GPE_OFS_INVERT_A 8'h0D
`define GPE_OFS_DIR_B 8'h0E
`define GPE_OFS_DIR_A 8'h0F
`define GPE_OFS_DATA_B 8'h10
`define GPE_OFS_DATA_A 8'h11
`define GPE_OFS_BLOCK_B 8'h12
`define GPE_OFS_BLOCK_A 8'h13
`define GPE_OFS_SEL_UP_B 8'h14
`define GPE_OFS_SEL_LO_B 8'h15
`define GPE_OFS_SEL_UP_A 8'h16
`define GPE_OFS_SEL_LO_A 8'h17
`define GPE_OFS_ORIGIN_B 8'h18
`define GPE_OFS_ORIGIN_A 8'h19
`define GPE_OFS_SEEN_B 8'h1A
`define GPE_OFS_SEEN_A 8'h1B
`define GPE_OFS_MISC 8'h1F

// ==========================================================
// reset values
`define GPE_RST_DIR 8'hFF
`define GPE_RST_DATA 8'hFF
`define GPE_RST_BLOCK 8'hFF
`define GPE_RST_SEL 8'h00
`define GPE_RST_FLAG 8'h00
`define GPE_RST_INVERT 8'h00
`define GPE_RST_MISC 8'h00

// ==========================================================
// field positions
`define GPE_MISC_AUTOCLR_OFF_BIT 0
`define GPE_MISC_ADDR_FIXED_BIT 1
`define GPE_SEL_RISE_BIT 0
`define GPE_SEL_FALL_BIT 1

// ==========================================================
// serial interface
`define GPE_DEV_ADDR 7'h3E

`endif

// ===== src/gpe_i2c_slave.v
`timescale 1ns/1ps
`default_nettype none

`include "gpe_consts.vh"

module gpe_i2c_slave #(
	parameter [6:0] DEV_ADDR = `GPE_DEV_ADDR
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_scl,
	input wire i_sda,
	input wire i_addr_fixed,
	input wire [7:0] i_rd_data,
	output reg o_sda_oe,
	output reg [7:0] o_reg_ptr,
	output reg [7:0] o_acc_addr,
	output reg o_wr_stb,
	output reg [7:0] o_wr_data,
	output reg o_rd_stb
);

	localparam [8:0] S_IDLE = 9'h001;
	localparam [8:0] S_DEV = 9'h002;
	localparam [8:0] S_DACK = 9'h004;
	localparam [8:0] S_REG = 9'h008;
	localparam [8:0] S_RACK = 9'h010;
	localparam [8:0] S_WR = 9'h020;
	localparam [8:0] S_WACK = 9'h040;
	localparam [8:0] S_RD = 9'h080;
	localparam [8:0] S_MACK = 9'h100;

	reg [8:0] state_r;
	reg [3:0] cnt_r;
	reg [7:0] shift_r;
	reg rw_r;
	reg nack_r;
	reg scl_d_r;
	reg sda_d_r;

	wire scl_rise = i_scl & ~scl_d_r;
	wire scl_fall = ~i_scl & scl_d_r;
	wire start_c = i_scl & scl_d_r & sda_d_r & ~i_sda;
	wire stop_c = i_scl & scl_d_r & ~sda_d_r & i_sda;
	wire load_rd = scl_fall & (((state_r == S_DACK) & rw_r) | ((state_r == S_MACK) & ~nack_r));
	wire [7:0] ptr_inc = i_addr_fixed ? o_reg_ptr : o_reg_ptr + 8'h01;

	// ==========================================================
	// byte engine; sda is only ever pulled low
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= S_IDLE;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			rw_r <= 1'b0;
			nack_r <= 1'b0;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			o_sda_oe <= 1'b0;
			o_reg_ptr <= 8'h00;
			o_acc_addr <= 8'h00;
			o_wr_stb <= 1'b0;
			o_wr_data <= 8'h00;
			o_rd_stb <= 1'b0;
		end else begin
			scl_d_r <= i_scl;
			sda_d_r <= i_sda;
			o_wr_stb <= 1'b0;
			o_rd_stb <= 1'b0;
			if (start_c) begin
				state_r <= S_DEV;
				cnt_r <= 4'h0;
				o_sda_oe <= 1'b0;
			end else if (stop_c) begin
				state_r <= S_IDLE;
				o_sda_oe <= 1'b0;
			end else if (load_rd) begin
				// read side effects fire when the byte is fetched
				shift_r <= i_rd_data;
				o_sda_oe <= ~i_rd_data[7];
				o_acc_addr <= o_reg_ptr;
				o_rd_stb <= 1'b1;
				o_reg_ptr <= ptr_inc;
				cnt_r <= 4'h0;
				state_r <= S_RD;
			end else begin
				case (state_r)
					S_DEV, S_REG, S_WR: begin
						if (scl_rise) begin
							shift_r <= {shift_r[6:0], i_sda};
							cnt_r <= cnt_r + 4'h1;
						end else if (scl_fall && cnt_r == 4'h8) begin
							cnt_r <= 4'h0;
							if (state_r == S_DEV) begin
								if (shift_r[7:1] == DEV_ADDR) begin
									rw_r <= shift_r[0];
									o_sda_oe <= 1'b1;
									state_r <= S_DACK;
								end else begin
									state_r <= S_IDLE;
								end
							end else if (state_r == S_REG) begin
								o_reg_ptr <= shift_r;
								o_sda_oe <= 1'b1;
								state_r <= S_RACK;
							end else begin
								o_acc_addr <= o_reg_ptr;
								o_wr_data <= shift_r;
								o_wr_stb <= 1'b1;
								o_sda_oe <= 1'b1;
								state_r <= S_WACK;
							end
						end
					end
					S_DACK, S_RACK, S_WACK: begin
						if (scl_fall) begin
							o_sda_oe <= 1'b0;
							if (state_r == S_DACK) begin
								state_r <= S_REG;
							end else begin
								state_r <= S_WR;
							end
							if (state_r == S_WACK) begin
								o_reg_ptr <= ptr_inc;
							end
						end
					end
					S_RD: begin
						if (scl_fall) begin
							if (cnt_r == 4'h7) begin
								o_sda_oe <= 1'b0;
								state_r <= S_MACK;
							end else begin
								shift_r <= {shift_r[6:0], 1'b0};
								o_sda_oe <= ~shift_r[6];
								cnt_r <= cnt_r + 4'h1;
							end
						end
					end
					S_MACK: begin
						if (scl_rise) begin
							nack_r <= i_sda;
						end else if (scl_fall) begin
							state_r <= S_IDLE;
						end
					end
					default: begin
						state_r <= S_IDLE;
					end
				endcase
			end
		end
	end

endmodule // gpe_i2c_slave

`default_nettype wire

// ===== src/gpe_bank_top.v
// Function
// - direction 0 output, 1 input; reset inputs
// - data write drives output lines; reset ones
// - data read returns present pin levels
// - only input lines may raise interrupt
// - mask 0 passes, 1 blocks; reset masked
// - code 00 none, 01 rise, 10 fall, 11 both
// - four codes per byte, high io top
// - matching edge sets event bit regardless mask
// - matching unmasked edge on an input line sets source bit
// - source write one clears source and event
// - event write one clears event and source
// - interrupt releases when all sources clear
// - sense change clears that event bit
// - source and event reset to zero
// - inversion flips data bit; edges use it
// - autoclear on: data read clears sources

`timescale 1ns/1ps
`default_nettype none

`include "gpe_consts.vh"

module gpe_bank_top #(
	parameter NUM_IO = 16,
	parameter [6:0] DEV_ADDR = `GPE_DEV_ADDR
) (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_scl,
	input wire i_sda,
	output reg o_sda_out,
	output wire o_sda_oe,
	input wire [NUM_IO-1:0] i_io_pin,
	output reg [NUM_IO-1:0] o_io_out,
	output reg [NUM_IO-1:0] o_io_oe,
	output reg o_irq_out_low_active
);

	// ==========================================================
	// reset release and pin synchronisers
	reg rst_s1_r;
	reg rst_n_r;
	reg [NUM_IO-1:0] pin_s1_r;
	reg [NUM_IO-1:0] pin_s2_r;
	reg scl_s1_r;
	reg scl_s2_r;
	reg sda_s1_r;
	reg sda_s2_r;

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	always @(posedge i_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pin_s1_r <= {NUM_IO{1'b0}};
			pin_s2_r <= {NUM_IO{1'b0}};
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
		end else begin
			pin_s1_r <= i_io_pin;
			pin_s2_r <= pin_s1_r;
			scl_s1_r <= i_scl;
			scl_s2_r <= scl_s1_r;
			sda_s1_r <= i_sda;
			sda_s2_r <= sda_s1_r;
		end
	end

	// ==========================================================
	// register state, bank b in the upper byte
	reg [NUM_IO-1:0] dir_r;
	reg [NUM_IO-1:0] dout_r;
	reg [NUM_IO-1:0] block_r;
	reg [NUM_IO-1:0] invert_r;
	reg [2*NUM_IO-1:0] sel_r;
	reg [NUM_IO-1:0] origin_r;
	reg [NUM_IO-1:0] seen_r;
	reg [NUM_IO-1:0] prev_val_r;
	reg autoclr_off_r;
	reg addr_fixed_r;

	wire [7:0] reg_ptr;
	wire [7:0] acc_addr;
	wire wr_stb;
	wire [7:0] wr_data;
	wire rd_stb;
	wire [7:0] rd_data;

	// ==========================================================
	// serial register port
	gpe_i2c_slave #(
		.DEV_ADDR(DEV_ADDR)
	) u_slave (
		.i_clk(i_clk),
		.i_rst_n(rst_n_r),
		.i_scl(scl_s2_r),
		.i_sda(sda_s2_r),
		.i_addr_fixed(addr_fixed_r),
		.i_rd_data(rd_data),
		.o_sda_oe(o_sda_oe),
		.o_reg_ptr(reg_ptr),
		.o_acc_addr(acc_addr),
		.o_wr_stb(wr_stb),
		.o_wr_data(wr_data),
		.o_rd_stb(rd_stb)
	);

	// ==========================================================
	// data bit view and edge detection
	// polarity applied
	wire [NUM_IO-1:0] val_now = pin_s2_r ^ invert_r;
	wire [NUM_IO-1:0] hit;
	wire [NUM_IO-1:0] sel_chg;
	reg [2*NUM_IO-1:0] sel_nxt;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_IO; gi = gi + 1) begin : g_io
			assign hit[gi] = (sel_r[2*gi+`GPE_SEL_RISE_BIT] & val_now[gi] & ~prev_val_r[gi]) |
				(sel_r[2*gi+`GPE_SEL_FALL_BIT] & ~val_now[gi] & prev_val_r[gi]);
			assign sel_chg[gi] = |(sel_nxt[2*gi+1:2*gi] ^ sel_r[2*gi+1:2*gi]);
		end
	endgenerate

	wire [NUM_IO-1:0] origin_set = hit & ~block_r & dir_r;

	// ==========================================================
	// flag clears and edge select update
	reg [NUM_IO-1:0] origin_clr;
	reg [NUM_IO-1:0] seen_clr;

	always @* begin
		origin_clr = {NUM_IO{1'b0}};
		seen_clr = {NUM_IO{1'b0}};
		sel_nxt = sel_r;
		if (wr_stb) begin
			if (acc_addr == `GPE_OFS_ORIGIN_B) begin
				origin_clr[15:8] = wr_data;
				seen_clr[15:8] = wr_data;
			end else if (acc_addr == `GPE_OFS_ORIGIN_A) begin
				origin_clr[7:0] = wr_data;
				seen_clr[7:0] = wr_data;
			end else if (acc_addr == `GPE_OFS_SEEN_B) begin
				seen_clr[15:8] = wr_data;
				origin_clr[15:8] = wr_data;
			end else if (acc_addr == `GPE_OFS_SEEN_A) begin
				seen_clr[7:0] = wr_data;
				origin_clr[7:0] = wr_data;
			end else if (acc_addr == `GPE_OFS_SEL_UP_B) begin
				sel_nxt[31:24] = wr_data;
			end else if (acc_addr == `GPE_OFS_SEL_LO_B) begin
				sel_nxt[23:16] = wr_data;
			end else if (acc_addr == `GPE_OFS_SEL_UP_A) begin
				sel_nxt[15:8] = wr_data;
			end else if (acc_addr == `GPE_OFS_SEL_LO_A) begin
				sel_nxt[7:0] = wr_data;
			end
		end
		if (rd_stb && !autoclr_off_r) begin
			if (acc_addr == `GPE_OFS_DATA_B) begin
				origin_clr[15:8] = 8'hFF;
			end else if (acc_addr == `GPE_OFS_DATA_A) begin
				origin_clr[7:0] = 8'hFF;
			end
		end
	end

	wire [NUM_IO-1:0] seen_nxt = (seen_r & ~(seen_clr | sel_chg)) | hit;
	wire [NUM_IO-1:0] origin_nxt = (origin_r & ~origin_clr) | origin_set;

	// ==========================================================
	// register file
	// misc reset kept as a byte so single bits can be picked out
	localparam [7:0] MISC_RST = `GPE_RST_MISC;

	always @(posedge i_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			dir_r <= {`GPE_RST_DIR, `GPE_RST_DIR};
			dout_r <= {`GPE_RST_DATA, `GPE_RST_DATA};
			block_r <= {`GPE_RST_BLOCK, `GPE_RST_BLOCK};
			invert_r <= {`GPE_RST_INVERT, `GPE_RST_INVERT};
			sel_r <= {`GPE_RST_SEL, `GPE_RST_SEL, `GPE_RST_SEL, `GPE_RST_SEL};
			origin_r <= {`GPE_RST_FLAG, `GPE_RST_FLAG};
			seen_r <= {`GPE_RST_FLAG, `GPE_RST_FLAG};
			prev_val_r <= {NUM_IO{1'b0}};
			autoclr_off_r <= MISC_RST[`GPE_MISC_AUTOCLR_OFF_BIT];
			addr_fixed_r <= MISC_RST[`GPE_MISC_ADDR_FIXED_BIT];
		end else begin
			// first sample after reset only primes history
			prev_val_r <= val_now;
			sel_r <= sel_nxt;
			seen_r <= seen_nxt;
			origin_r <= origin_nxt;
			if (wr_stb) begin
				if (acc_addr == `GPE_OFS_DIR_B) begin
					dir_r[15:8] <= wr_data;
				end else if (acc_addr == `GPE_OFS_DIR_A) begin
					dir_r[7:0] <= wr_data;
				end else if (acc_addr == `GPE_OFS_DATA_B) begin
					dout_r[15:8] <= wr_data;
				end else if (acc_addr == `GPE_OFS_DATA_A) begin
					dout_r[7:0] <= wr_data;
				end else if (acc_addr == `GPE_OFS_BLOCK_B) begin
					block_r[15:8] <= wr_data;
				end else if (acc_addr == `GPE_OFS_BLOCK_A) begin
					block_r[7:0] <= wr_data;
				end else if (acc_addr == `GPE_OFS_INVERT_B) begin
					invert_r[15:8] <= wr_data;
				end else if (acc_addr == `GPE_OFS_INVERT_A) begin
					invert_r[7:0] <= wr_data;
				end else if (acc_addr == `GPE_OFS_MISC) begin
					autoclr_off_r <= wr_data[`GPE_MISC_AUTOCLR_OFF_BIT];
					addr_fixed_r <= wr_data[`GPE_MISC_ADDR_FIXED_BIT];
				end
			end
		end
	end

	// ==========================================================
	// read mux
	function [7:0] reg_read;
		input [7:0] addr;
		begin
			reg_read = 8'h00;
			if (addr == `GPE_OFS_INVERT_B) begin
				reg_read = invert_r[15:8];
			end else if (addr == `GPE_OFS_INVERT_A) begin
				reg_read = invert_r[7:0];
			end else if (addr == `GPE_OFS_DIR_B) begin
				reg_read = dir_r[15:8];
			end else if (addr == `GPE_OFS_DIR_A) begin
				reg_read = dir_r[7:0];
			end else if (addr == `GPE_OFS_DATA_B) begin
				reg_read = val_now[15:8];
			end else if (addr == `GPE_OFS_DATA_A) begin
				reg_read = val_now[7:0];
			end else if (addr == `GPE_OFS_BLOCK_B) begin
				reg_read = block_r[15:8];
			end else if (addr == `GPE_OFS_BLOCK_A) begin
				reg_read = block_r[7:0];
			end else if (addr == `GPE_OFS_SEL_UP_B) begin
				reg_read = sel_r[31:24];
			end else if (addr == `GPE_OFS_SEL_LO_B) begin
				reg_read = sel_r[23:16];
			end else if (addr == `GPE_OFS_SEL_UP_A) begin
				reg_read = sel_r[15:8];
			end else if (addr == `GPE_OFS_SEL_LO_A) begin
				reg_read = sel_r[7:0];
			end else if (addr == `GPE_OFS_ORIGIN_B) begin
				reg_read = origin_r[15:8];
			end else if (addr == `GPE_OFS_ORIGIN_A) begin
				reg_read = origin_r[7:0];
			end else if (addr == `GPE_OFS_SEEN_B) begin
				reg_read = seen_r[15:8];
			end else if (addr == `GPE_OFS_SEEN_A) begin
				reg_read = seen_r[7:0];
			end else if (addr == `GPE_OFS_MISC) begin
				reg_read = {6'h00, addr_fixed_r, autoclr_off_r};
			end
		end
	endfunction

	assign rd_data = reg_read(reg_ptr);

	// ==========================================================
	// pin and interrupt outputs
	always @(posedge i_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_sda_out <= 1'b0;
			o_io_out <= {`GPE_RST_DATA, `GPE_RST_DATA};
			o_io_oe <= {NUM_IO{1'b0}};
			o_irq_out_low_active <= 1'b1;
		end else begin
			o_sda_out <= 1'b0;
			o_io_out <= dout_r ^ invert_r;
			o_io_oe <= ~dir_r;
			o_irq_out_low_active <= ~|origin_nxt;
		end
	end

endmodule // gpe_bank_top

`default_nettype wire

// ===== tb/gpe_bank_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module gpe_bank_monitor #(parameter NUM_IO = 16) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda_out,
	input wire logic o_sda_oe,
	input wire logic [NUM_IO-1:0] i_io_pin,
	input wire logic [NUM_IO-1:0] o_io_out,
	input wire logic [NUM_IO-1:0] o_io_oe,
	input wire logic o_irq_out_low_active
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// ====================
	// reset state
	dir_reset_a:
		assert property ($rose(i_reset_n) |-> o_io_oe == '0) else $error("lines driven after reset");
	out_reset_a:
		assert property ($rose(i_reset_n) |-> o_io_out == '1) else $error("output data not ones after reset");
	irq_reset_a:
		assert property ($rose(i_reset_n) |-> o_irq_out_low_active) else $error("irq active after reset");
	// ====================
	// host writes land in scl low
	dir_timing_a:
		assert property (!$stable(o_io_oe) |-> !i_scl) else $error("direction moved outside a write");
	out_timing_a:
		assert property (!$stable(o_io_out) |-> !i_scl) else $error("output data moved outside a write");
	irq_clear_a:
		assert property ($rose(o_irq_out_low_active) |-> !i_scl) else $error("irq released outside an access");
	// ====================
	// irq cause: window spans sync plus flag latency
	irq_cause_a:
		assert property ($fell(o_irq_out_low_active) |-> |(~o_io_oe & (($past(i_io_pin, 3) ^ $past(i_io_pin, 4))
			| ($past(i_io_pin, 4) ^ $past(i_io_pin, 5)) | ($past(i_io_pin, 5) ^ $past(i_io_pin, 6)))))
			else $error("irq without an input edge");
	irq_hold_a:
		assert property ($fell(o_irq_out_low_active) |=> !o_irq_out_low_active [*8]) else $error("irq too short");
	sda_open_drain_a:
		assert property (o_sda_out == 1'b0) else $error("sda driven high");
	irq_fall_c: cover property ($fell(o_irq_out_low_active));
	irq_rise_c: cover property ($rose(o_irq_out_low_active));
	dir_out_c: cover property ($rose(|o_io_oe));
endmodule // gpe_bank_monitor

bind gpe_bank_top gpe_bank_monitor #(.NUM_IO(NUM_IO)) gpe_bank_monitor_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_io_pin(i_io_pin),
	.o_io_out(o_io_out), .o_io_oe(o_io_oe), .o_irq_out_low_active(o_irq_out_low_active));
`default_nettype wire

// ===== tb/gpe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpe_host_model #(parameter [6:0] DEV_ADDR = 7'h3E, parameter HALF = 16) (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	logic ack_ok;
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
		ack_ok = 1'b1;
	end
	task automatic wait_n(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	// ====================
	// bit level; sda moves only well after scl fell
	task automatic clk_bit(input logic b, output logic s);
		wait_n(4);
		o_sda_low = !b;
		wait_n(HALF);
		o_scl = 1'b1;
		wait_n(HALF);
		s = i_sda;
		o_scl = 1'b0;
	endtask
	task automatic cond(input logic is_start);
		wait_n(4);
		o_sda_low = !is_start;
		wait_n(HALF);
		o_scl = 1'b1;
		wait_n(HALF);
		o_sda_low = is_start;
		wait_n(HALF);
		o_scl = !is_start;
	endtask
	task automatic xfer(input logic [7:0] v, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) clk_bit(v[i], r[i]);
		clk_bit(1'b1, a);
	endtask
	task automatic put(input logic [7:0] v);
		logic [7:0] r;
		logic a;
		xfer(v, r, a);
		if (a !== 1'b0) ack_ok = 1'b0;
	endtask
	// ====================
	// register accesses; a read ends with nack
	task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data);
		cond(1'b1);
		put({DEV_ADDR, 1'b0});
		put(ptr);
		put(data);
		cond(1'b0);
	endtask
	task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data);
		logic a;
		cond(1'b1);
		put({DEV_ADDR, 1'b0});
		put(ptr);
		cond(1'b1);
		put({DEV_ADDR, 1'b1});
		xfer(8'hFF, data, a);
		cond(1'b0);
	endtask
endmodule // gpe_host_model
`default_nettype wire

// ===== tb/gpe_bank_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module gpe_bank_top_test;
	logic i_clk;
	logic i_reset_n;
	logic [15:0] ext_pins;
	logic scl;
	logic host_sda_low;
	logic sda_oe;
	logic [15:0] io_out;
	logic [15:0] io_oe;
	logic irq_low_active;
	int miscompares;
	int samples_checked;
	wire logic sda = !(host_sda_low || sda_oe);
	// driven lines show the device, the rest the outside world
	wire logic [15:0] pins = (io_oe & io_out) | (~io_oe & ext_pins);
	gpe_bank_top gpe_bank_top_i (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_scl(scl),
		.i_sda(sda),
		.o_sda_out(),
		.o_sda_oe(sda_oe),
		.i_io_pin(pins),
		.o_io_out(io_out),
		.o_io_oe(io_oe),
		.o_irq_out_low_active(irq_low_active)
	);
	gpe_host_model gpe_host_model_i (
		.i_clk(i_clk),
		.i_sda(sda),
		.o_scl(scl),
		.o_sda_low(host_sda_low)
	);
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = !i_clk;
	end
	// ====================
	// helpers
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic test_done();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
		gpe_host_model_i.write_reg(ptr, data);
		check("ack", 16'h0001, {15'h0000, gpe_host_model_i.ack_ok});
	endtask
	task automatic rd(input logic [7:0] ptr, input logic [7:0] exp, input string what);
		logic [7:0] got;
		gpe_host_model_i.read_reg(ptr, got);
		check("ack", 16'h0001, {15'h0000, gpe_host_model_i.ack_ok});
		check(what, {8'h00, exp}, {8'h00, got});
	endtask
	task automatic irq_is(input logic exp);
		check("irq", {15'h0000, exp}, {15'h0000, irq_low_active});
	endtask
	task automatic pins_a(input logic [7:0] v);
		ext_pins[7:0] = v;
		tick(8);
	endtask
	// ====================
	// scenarios
	task automatic test_reset();
		logic [7:0] ofs;
		check("oe", 16'h0000, io_oe);
		irq_is(1'b1);
		for (ofs = 8'h0F; ofs <= 8'h1B; ofs++) begin
			rd(ofs, (ofs <= 8'h13) ? 8'hFF : 8'h00, "reset");
		end
		wr(8'h30, 8'h00);
		rd(8'h30, 8'h00, "unmapped");
	endtask
	task automatic test_direction();
		wr(8'h0F, 8'h0F);
		wr(8'h11, 8'hA5);
		check("oe", 16'h00F0, io_oe);
		check("out", 16'h00A0, io_out & io_oe);
		pins_a(8'h3C);
		rd(8'h11, 8'hAC, "data a");
		wr(8'h0F, 8'hFF);
		pins_a(8'h00);
	endtask
	task automatic test_edges();
		wr(8'h17, 8'hE4);
		wr(8'h13, 8'hF5);
		pins_a(8'h0F);
		irq_is(1'b0);
		rd(8'h1B, 8'h0A, "event");
		rd(8'h19, 8'h0A, "source");
		wr(8'h19, 8'h02);
		rd(8'h1B, 8'h08, "event");
		irq_is(1'b0);
		wr(8'h19, 8'h08);
		irq_is(1'b1);
		pins_a(8'h00);
		rd(8'h1B, 8'h0C, "event");
		rd(8'h19, 8'h08, "source");
		wr(8'h1B, 8'h0C);
		rd(8'h19, 8'h00, "source");
		irq_is(1'b1);
	endtask
	task automatic test_autoclear();
		pins_a(8'h08);
		rd(8'h11, 8'h08, "data a");
		irq_is(1'b1);
		rd(8'h19, 8'h00, "source");
		wr(8'h1B, 8'h08);
		wr(8'h1F, 8'h01);
		pins_a(8'h00);
		rd(8'h11, 8'h00, "data a");
		rd(8'h19, 8'h08, "source");
		wr(8'h19, 8'h08);
		rd(8'h1B, 8'h00, "event");
		irq_is(1'b1);
	endtask
	task automatic test_sense_output();
		pins_a(8'h02);
		wr(8'h17, 8'hE8);
		rd(8'h1B, 8'h00, "event");
		rd(8'h19, 8'h02, "source");
		wr(8'h19, 8'h02);
		wr(8'h0F, 8'hF7);
		wr(8'h11, 8'hAD);
		tick(8);
		irq_is(1'b1);
		rd(8'h1B, 8'h08, "event");
		rd(8'h19, 8'h00, "source");
		pins_a(8'h0A);
		wr(8'h0F, 8'hFF);
		wr(8'h1B, 8'h08);
		wr(8'h0D, 8'h01);
		rd(8'h11, 8'h0B, "data a");
		wr(8'h0D, 8'h00);
		irq_is(1'b1);
	endtask
	// ====================
	// main sequence and hang guard
	initial begin
		miscompares = 0;
		samples_checked = 0;
		i_reset_n = 1'b0;
		ext_pins = 16'hFFFF;
		repeat (8) @(posedge i_clk);
		#1;
		i_reset_n = 1'b1;
		tick(4);
		test_reset();
		test_direction();
		test_edges();
		test_autoclear();
		test_sense_output();
		test_done();
	end
	initial begin
		repeat (100000) @(posedge i_clk);
		miscompares++;
		test_done();
	end
endmodule // gpe_bank_top_test
`default_nettype wire
